// >>> inc/pbc_pkg.sv
package pbc_pkg;

   // ------------------------------------------------------------
   // widths and timing
   // ------------------------------------------------------------
   localparam int unsigned NCELL         = 12;
   localparam int unsigned CLK_PERIOD_PS = 5000;
   localparam int unsigned SETTLE_LSB_NS = 1000;
   localparam int unsigned SETTLE_LSB_CYC = (SETTLE_LSB_NS * 1000) / CLK_PERIOD_PS;
   localparam logic [7:0]  TICK_LAST     = 8'(SETTLE_LSB_CYC - 1);

   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_ENABLE   = 8'h00;
   localparam logic [7:0] OFS_MEASCTL  = 8'h04;
   localparam logic [7:0] OFS_DIAG     = 8'h08;
   localparam logic [7:0] OFS_CELLOFF  = 8'h0c;
   localparam logic [7:0] OFS_IRQMASK  = 8'h10;
   localparam logic [7:0] OFS_STATUS   = 8'h14;
   localparam logic [7:0] OFS_OCLIMIT  = 8'h18;

   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int unsigned POS_PAUSE    = 0;
   localparam int unsigned POS_SETTLE   = 8;
   localparam int unsigned POS_RRACT    = 16;
   localparam int unsigned POS_MSTATE   = 17;
   localparam int unsigned D_OC         = 0;
   localparam int unsigned D_UC         = 1;
   localparam int unsigned D_OV         = 2;
   localparam int unsigned D_UV         = 3;
   localparam int unsigned D_GLOB       = 4;
   localparam int unsigned NDIAG        = 10;
   localparam logic [7:0] SETTLE_RST    = 8'h00;
   localparam logic [3:0] OCLIMIT_RST   = 4'h1;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      M_IDLE    = 2'b00,
      M_SETTLE  = 2'b01,
      M_CONVERT = 2'b10
   } pbc_meas_t;

   typedef struct packed {
      logic       psel;
      logic       penable;
      logic       pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } pbc_apb_req_t;

   // order matches general_diag_reg bits 9..4
   typedef struct packed {
      logic adc;
      logic open_wire_fault_flag;
      logic chip_internal_fault_flag;
      logic crc;
      logic thermistor_fault_flag;
      logic die_overtemp_flag;
   } pbc_glob_err_t;

   typedef struct packed {
      logic [NCELL-1:0] en;
      logic             pause;
      logic [7:0]       settle;
      logic [NDIAG-1:0] diag;
      logic [NCELL-1:0] cell_off;
      logic [NDIAG-1:0] mask;
      logic [3:0]       oc_lim;
      pbc_meas_t        meas;
      logic [7:0]       settle_cnt;
      logic [7:0]       tick_cnt;
      logic             rr_active;
      logic [NCELL-1:0] rr_snap;
      logic             asleep;
      logic [NCELL-1:0] drive;
      logic             meas_start;
      logic             irq;
      logic             pready;
      logic             pslverr;
      logic [31:0]      prdata;
   } pbc_state_t;

endpackage : pbc_pkg

// >>> src/pbc_balance.sv
// ------------------------------------------------------------
// Summary of operation
// - an enable bit of one closes that cell's shunt switch
// - switch stays closed until enable cleared, sleep, or a fault
// - pause bit set opens all switches from settling start until the conversion is done
// - settling delay from the control field precedes each measurement start
// - settling delay is inserted every time, balancing or not
// - periodic check cycle opens all switches, resumes after, ignores pause bit
// - cells balancing at check start get overcurrent and undercurrent checks
// - separate sticky overcurrent and undercurrent flags in diagnosis register
// - current and cell voltage errors disable only the affected cells
// - temperature, crc, internal, open wire, adc errors disable all cells
// - overcurrent reported within one check cycle when limit is one
// - twelve enables act independently in any combination
// ------------------------------------------------------------
`timescale 1ns/1ps
module pbc_balance
   import pbc_pkg::*;
#(
   parameter int unsigned N = NCELL
)(
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          srst,
   // apb slave
   input  wire pbc_apb_req_t  apb,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   // measurement sequencer
   input  wire logic          meas_req,
   input  wire logic          conv_done,
   output logic               meas_start,
   // periodic check cycle
   input  wire logic          rr_start,
   input  wire logic          rr_done,
   input  wire logic [N-1:0]  oc_fault,
   input  wire logic [N-1:0]  uc_fault,
   output logic [N-1:0]       rr_check_mask,
   // fault sources
   input  wire logic [N-1:0]  cell_high_voltage_flag,
   input  wire logic [N-1:0]  cell_low_voltage_flag,
   input  wire pbc_glob_err_t glob_err,
   input  wire logic          sleep,
   // outputs
   output logic [N-1:0]       shunt_drive,
   output logic               irq
);

   pbc_state_t st;
   pbc_state_t next_st;
   logic [N-1:0] oc_hit;
   logic [N-1:0] uc_hit;
   logic         rr_eval;
   logic         wr;
   logic         rd;
   logic         gate;
   logic [31:0]  rdata;
   logic         mapped;

   assign rr_eval = rr_done && st.rr_active;
   assign wr      = apb.psel && apb.penable && st.pready && apb.pwrite;
   assign rd      = apb.psel && apb.penable && !st.pready;

   // ------------------------------------------------------------
   // overcurrent / undercurrent counters
   // ------------------------------------------------------------
   pbc_fault_count #(.N(N)) u_oc (
      .mclk  (mclk),
      .srst  (srst),
      .eval  (rr_eval),
      .check (st.rr_snap),
      .fault (oc_fault),
      .limit (st.oc_lim),
      .hit   (oc_hit)
   );

   // undercurrent has no programmable limit: one strike reports
   pbc_fault_count #(.N(N)) u_uc (
      .mclk  (mclk),
      .srst  (srst),
      .eval  (rr_eval),
      .check (st.rr_snap),
      .fault (uc_fault),
      .limit (OCLIMIT_RST),
      .hit   (uc_hit)
   );

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   always_comb
   begin
      rdata  = '0;
      mapped = 1'b1;
      unique case (apb.paddr)
         OFS_ENABLE:  rdata[N-1:0] = st.en;
         OFS_MEASCTL:
         begin
            rdata[POS_PAUSE]               = st.pause;
            rdata[POS_SETTLE +: 8]         = st.settle;
         end
         OFS_DIAG:    rdata[NDIAG-1:0] = st.diag;
         OFS_CELLOFF: rdata[N-1:0] = st.cell_off;
         OFS_IRQMASK: rdata[NDIAG-1:0] = st.mask;
         OFS_STATUS:
         begin
            rdata[N-1:0]             = st.drive;
            rdata[POS_RRACT]         = st.rr_active;
            rdata[POS_MSTATE +: 2]   = st.meas;
         end
         OFS_OCLIMIT: rdata[3:0] = st.oc_lim;
         default:     mapped = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      next_st            = st;
      next_st.meas_start = 1'b0;
      next_st.asleep     = sleep;

      // one wait state: ready in the second access cycle
      next_st.pready  = rd;
      next_st.pslverr = rd && !mapped;
      next_st.prdata  = (rd && mapped && !apb.pwrite) ? rdata : 32'h0;

      if (wr)
      begin
         unique case (apb.paddr)
            OFS_ENABLE:  next_st.en = apb.pwdata[N-1:0];
            OFS_MEASCTL:
            begin
               next_st.pause  = apb.pwdata[POS_PAUSE];
               next_st.settle = apb.pwdata[POS_SETTLE +: 8];
            end
            OFS_DIAG:    next_st.diag = st.diag & ~apb.pwdata[NDIAG-1:0];
            OFS_CELLOFF: next_st.cell_off = st.cell_off & ~apb.pwdata[N-1:0];
            OFS_IRQMASK: next_st.mask = apb.pwdata[NDIAG-1:0];
            OFS_OCLIMIT: next_st.oc_lim = apb.pwdata[3:0];
            default:     next_st.en = st.en;
         endcase
      end

      // hardware sets after the clear so a same-cycle event wins
      next_st.cell_off = next_st.cell_off | oc_hit | uc_hit
                       | cell_high_voltage_flag | cell_low_voltage_flag;
      if (|oc_hit)
         next_st.diag[D_OC] = 1'b1;
      if (|uc_hit)
         next_st.diag[D_UC] = 1'b1;
      if (|cell_high_voltage_flag)
         next_st.diag[D_OV] = 1'b1;
      if (|cell_low_voltage_flag)
         next_st.diag[D_UV] = 1'b1;
      next_st.diag[NDIAG-1:D_GLOB] = next_st.diag[NDIAG-1:D_GLOB] | glob_err;

      // periodic check cycle; snapshot which cells were balancing
      if (rr_start && !st.rr_active)
      begin
         next_st.rr_active = 1'b1;
         next_st.rr_snap   = st.drive;
      end
      else if (rr_eval)
         next_st.rr_active = 1'b0;

      // measurement: the settling wait runs on every request
      unique case (st.meas)
         M_IDLE:
         begin
            if (meas_req)
            begin
               next_st.meas       = M_SETTLE;
               next_st.settle_cnt = st.settle;
               next_st.tick_cnt   = TICK_LAST;
            end
         end
         M_SETTLE:
         begin
            if (st.tick_cnt != 8'h0)
               next_st.tick_cnt = st.tick_cnt - 8'h1;
            else if (st.settle_cnt != 8'h0)
            begin
               next_st.tick_cnt   = TICK_LAST;
               next_st.settle_cnt = st.settle_cnt - 8'h1;
            end
            else
            begin
               next_st.meas       = M_CONVERT;
               next_st.meas_start = 1'b1;
            end
         end
         M_CONVERT:
         begin
            if (conv_done)
               next_st.meas = M_IDLE;
         end
         default: next_st.meas = M_IDLE;
      endcase

      // drive follows the new state so the output flop matches it
      gate = next_st.asleep || next_st.rr_active
           || (next_st.pause && next_st.meas != M_IDLE)
           || (|next_st.diag[NDIAG-1:D_GLOB]);
      next_st.drive = gate ? '0 : (next_st.en & ~next_st.cell_off);
      next_st.irq   = |(next_st.diag & next_st.mask);
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         st        <= '0;
         st.settle <= SETTLE_RST;
         st.oc_lim <= OCLIMIT_RST;
         st.meas   <= M_IDLE;
      end
      else
         st <= next_st;
   end

   assign prdata        = st.prdata;
   assign pready        = st.pready;
   assign pslverr       = st.pslverr;
   assign meas_start    = st.meas_start;
   assign rr_check_mask = st.rr_snap;
   assign shunt_drive   = st.drive;
   assign irq           = st.irq;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   logic [15:0] settle_len;
   always_ff @(posedge mclk)
   begin
      if (srst || st.meas != M_SETTLE)
         settle_len <= 16'h0;
      else
         settle_len <= settle_len + 16'h1;
   end

   sequence s_rr_begin;
      !st.rr_active ##1 st.rr_active;
   endsequence

   a_enable_drives: assert property (
      (!st.asleep && !st.rr_active && st.meas == M_IDLE && st.diag[NDIAG-1:D_GLOB] == '0
       && st.cell_off == '0) |-> shunt_drive == st.en)
      else $error("enabled cell not driven");

   a_sleep_opens: assert property (
      st.asleep |-> shunt_drive == '0)
      else $error("switch closed while asleep");

   a_pause_opens: assert property (
      (st.pause && st.meas != M_IDLE) |-> shunt_drive == '0)
      else $error("switch closed during paused conversion");

   a_settle_len: assert property (
      meas_start |-> settle_len == (16'(st.settle) + 16'h1) * 16'(SETTLE_LSB_CYC))
      else $error("settling delay wrong length");

   a_settle_always: assert property (
      (st.meas == M_IDLE && meas_req) |=> st.meas == M_SETTLE ##1 !meas_start)
      else $error("measurement started without settling");

   a_rr_opens: assert property (
      st.rr_active |-> shunt_drive == '0)
      else $error("switch closed during check cycle");

   a_rr_snapshot: assert property (
      s_rr_begin |-> rr_check_mask == $past(shunt_drive))
      else $error("check mask not taken from drive");

   a_oc_flag: assert property (
      (|oc_hit) |=> st.diag[D_OC] && ((st.cell_off & $past(oc_hit)) == $past(oc_hit)))
      else $error("overcurrent not flagged");

   a_global_off: assert property (
      (|st.diag[NDIAG-1:D_GLOB]) |-> shunt_drive == '0)
      else $error("switch closed under global fault");

   a_oc_one_cycle: assert property (
      (rr_eval && st.oc_lim == 4'h1 && (|(oc_fault & st.rr_snap))) |=> st.diag[D_OC])
      else $error("overcurrent missed with limit one");

endmodule : pbc_balance

// >>> src/pbc_fault_count.sv
`timescale 1ns/1ps
// per-cell consecutive fault counters; hit is combinational so the
// caller can act in the same cycle the check cycle closes
module pbc_fault_count
   import pbc_pkg::*;
#(
   parameter int unsigned N = 12
)(
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         srst,
   // evaluation
   input  wire logic         eval,
   input  wire logic [N-1:0] check,
   input  wire logic [N-1:0] fault,
   input  wire logic [3:0]   limit,
   output logic [N-1:0]      hit
);

   typedef struct packed {
      logic [N-1:0][3:0] cnt;
   } pbc_cnt_t;

   pbc_cnt_t st;
   pbc_cnt_t next_st;
   logic [3:0] lim;

   // a limit of zero behaves like one: never leave a fault unreported
   assign lim = (limit == 4'h0) ? 4'h1 : limit;

   always_comb
   begin
      next_st = st;
      hit     = '0;
      for (int i = 0; i < N; i++)
      begin
         if (eval && check[i])
         begin
            if (!fault[i])
               next_st.cnt[i] = 4'h0;
            else if (st.cnt[i] + 4'h1 >= lim)
            begin
               hit[i]         = 1'b1;
               next_st.cnt[i] = 4'h0;
            end
            else
               next_st.cnt[i] = st.cnt[i] + 4'h1;
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
         st <= '0;
      else
         st <= next_st;
   end

endmodule : pbc_fault_count

// >>> verification/passive_cell_balancing_control_bench.sv
`timescale 1ns/1ps
module passive_cell_balancing_control_bench
   import pbc_pkg::*;
;
   logic             mclk, srst, meas_req, conv_done, rr_start, rr_done, sleep;
   logic             pready, pslverr, meas_start, irq;
   logic [NCELL-1:0] oc_fault, uc_fault, cv_hi, cv_lo, shunt_drive, rr_check_mask;
   logic [31:0]      prdata;
   pbc_glob_err_t    glob_err;
   pbc_apb_req_t     apb;
   int               err_count, num_checks, cyc;
   logic [12:0]      row_in  [5] = '{13'h0001, 13'h0fff, 13'h0a5a, 13'h1fff, 13'h0800};
   logic [11:0]      row_out [5] = '{12'h001, 12'hfff, 12'ha5a, 12'h000, 12'h800};
   logic [7:0]       rst_a   [5] = '{OFS_ENABLE, OFS_MEASCTL, OFS_DIAG, OFS_IRQMASK, OFS_OCLIMIT};
   logic [31:0]      rst_v   [5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1};

   pbc_balance #(.N(NCELL)) i_pbc_balance (.mclk(mclk), .srst(srst), .apb(apb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas_req(meas_req),
      .conv_done(conv_done), .meas_start(meas_start), .rr_start(rr_start),
      .rr_done(rr_done), .oc_fault(oc_fault), .uc_fault(uc_fault),
      .rr_check_mask(rr_check_mask), .cell_high_voltage_flag(cv_hi),
      .cell_low_voltage_flag(cv_lo), .glob_err(glob_err), .sleep(sleep),
      .shunt_drive(shunt_drive), .irq(irq));
   pbc_host_model i_pbc_host_model (.mclk(mclk), .apb(apb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));

   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      i_pbc_host_model.xfer(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      i_pbc_host_model.xfer(1'b0, a, 32'h0, r, e);
      chk(what, r, exp);
   endtask : rd_chk

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish

   // settle window, then conversion, with drive checked once in settle, once in convert and once after
   task automatic measure(input logic pz, input logic [7:0] st, input logic [11:0] en);
      int n;
      int t;
      t = (int'(st) + 1) * SETTLE_LSB_CYC;
      wr(OFS_MEASCTL, {16'h0, st, 7'h0, pz});
      @(posedge mclk);
      meas_req <= 1'b1;
      @(posedge mclk);
      meas_req <= 1'b0;
      @(negedge mclk);
      chk("drive in settle", 32'(shunt_drive), 32'(pz ? 12'h0 : en));
      n = 1;
      while (meas_start !== 1'b1 && n < 4000)
      begin
         @(negedge mclk);
         n++;
      end
      chk("settle cycles", 32'(n >= t && n <= t + 1), 32'h1);
      repeat (3) @(negedge mclk);
      chk("drive in convert", 32'(shunt_drive), 32'(pz ? 12'h0 : en));
      @(posedge mclk);
      conv_done <= 1'b1;
      @(posedge mclk);
      conv_done <= 1'b0;
      repeat (3) @(negedge mclk);
      chk("drive after convert", 32'(shunt_drive), 32'(en));
   endtask : measure

   task automatic rr_cycle(input logic [11:0] en, input logic [11:0] oc, input logic [11:0] uc);
      @(posedge mclk);
      rr_start <= 1'b1;
      @(posedge mclk);
      rr_start <= 1'b0;
      repeat (2) @(negedge mclk);
      chk("check mask", 32'(rr_check_mask), 32'(en));
      chk("drive in check", 32'(shunt_drive), 32'h0);
      rd_chk("status in check", OFS_STATUS, 32'h00010000);
      @(posedge mclk);
      rr_done  <= 1'b1;
      oc_fault <= oc;
      uc_fault <= uc;
      @(posedge mclk);
      rr_done  <= 1'b0;
      oc_fault <= '0;
      uc_fault <= '0;
      repeat (2) @(negedge mclk);
   endtask : rr_cycle

   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         tally_and_finish();
      end
   end

   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial
   begin
      {srst, meas_req, conv_done, rr_start, rr_done, sleep} = 6'h20;
      {oc_fault, uc_fault, cv_hi, cv_lo} = '0;
      glob_err = '0;
      {err_count, num_checks, cyc} = '0;
      repeat (8) @(posedge mclk);
      srst <= 1'b0;
      // sleep only gates the drive; the enables survive it
      foreach (row_in[i])
      begin
         @(posedge mclk);
         sleep <= row_in[i][12];
         wr(OFS_ENABLE, {20'h0, row_in[i][11:0]});
         repeat (3) @(negedge mclk);
         chk("shunt_drive", 32'(shunt_drive), 32'(row_out[i]));
         rd_chk("enable", OFS_ENABLE, {20'h0, row_in[i][11:0]});
         rd_chk("status", OFS_STATUS, {20'h0, row_out[i]});
      end
      $display("test table done");
      @(posedge mclk);
      sleep <= 1'b0;
      srst  <= 1'b1;
      repeat (8) @(posedge mclk);
      srst <= 1'b0;
      foreach (rst_a[i])
         rd_chk("reset value", rst_a[i], rst_v[i]);
      begin
         logic [31:0] r;
         logic        e;
         i_pbc_host_model.xfer(1'b1, 8'h1c, 32'hffff, r, e);
         chk("unmapped error", 32'(e), 32'h1);
      end
      $display("test reset done");
      wr(OFS_ENABLE, 32'hfff);
      measure(1'b1, 8'h00, 12'hfff);
      wr(OFS_ENABLE, 32'h5a5);
      measure(1'b0, 8'h01, 12'h5a5);
      $display("test measure done");
      wr(OFS_ENABLE, 32'hfff);
      wr(OFS_MEASCTL, 32'h1);
      rr_cycle(12'hfff, 12'h000, 12'h000);
      chk("drive resumes", 32'(shunt_drive), 32'hfff);
      rr_cycle(12'hfff, 12'h001, 12'h002);
      chk("drive after faults", 32'(shunt_drive), 32'hffc);
      rd_chk("diag current", OFS_DIAG, 32'h3);
      rd_chk("cell off", OFS_CELLOFF, 32'h3);
      wr(OFS_IRQMASK, 32'h1);
      @(negedge mclk);
      chk("irq set", 32'(irq), 32'h1);
      wr(OFS_DIAG, 32'h3);
      @(negedge mclk);
      chk("irq clear", 32'(irq), 32'h0);
      chk("cell still off", 32'(shunt_drive), 32'hffc);
      wr(OFS_CELLOFF, 32'h3);
      @(posedge mclk);
      cv_hi <= 12'h020;
      cv_lo <= 12'h040;
      @(posedge mclk);
      cv_hi <= '0;
      cv_lo <= '0;
      repeat (2) @(negedge mclk);
      chk("voltage fault drive", 32'(shunt_drive), 32'hf9f);
      rd_chk("diag voltage", OFS_DIAG, 32'hc);
      wr(OFS_DIAG, 32'hc);
      wr(OFS_CELLOFF, 32'h60);
      $display("test check cycle done");
      for (int i = 0; i < 6; i++)
      begin
         @(posedge mclk);
         glob_err <= pbc_glob_err_t'(6'h01 << i);
         @(posedge mclk);
         glob_err <= '0;
         repeat (2) @(negedge mclk);
         chk("global fault drive", 32'(shunt_drive), 32'h0);
         rd_chk("diag global", OFS_DIAG, 32'h10 << i);
         wr(OFS_DIAG, 32'h10 << i);
         repeat (2) @(negedge mclk);
         chk("drive back", 32'(shunt_drive), 32'hfff);
      end
      $display("test global faults done");
      wr(OFS_OCLIMIT, 32'h2);
      rr_cycle(12'hfff, 12'h004, 12'h000);
      chk("oc below limit", 32'(shunt_drive), 32'hfff);
      rr_cycle(12'hfff, 12'h004, 12'h000);
      chk("oc at limit", 32'(shunt_drive), 32'hffb);
      rd_chk("diag oc count", OFS_DIAG, 32'h1);
      $display("test oc limit done");
      tally_and_finish();
   end
endmodule : passive_cell_balancing_control_bench

// >>> verification/pbc_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// host side of the register bus
// ------------------------------------------------------------
module pbc_host_model
   import pbc_pkg::*;
(
   // clock
   input  wire logic        mclk,
   // apb master
   output pbc_apb_req_t     apb,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial apb = '0;

   // the host starts and stops balancing only through these transfers
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic err);
      @(posedge mclk);
      apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
      @(posedge mclk);
      apb.penable <= 1'b1;
      // no cycle count assumed here: a dead slave is caught by the bench timeout
      do
      begin
         @(posedge mclk);
      end
      while (pready !== 1'b1);
      rdata = prdata;
      err   = pslverr;
      apb <= '0;
   endtask : xfer
endmodule : pbc_host_model
